// ### hdl/dead_band_timer_ctrl.sv
// Timer and DMA controller end: delay timers, pulse timer, DMA event.
// Assumes software on a plain strobe port and the cell end on the link.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps

module dead_band_timer_ctrl (
    input  wire logic                           i_clk,
    input  wire logic                           i_sys_rst,
    dead_band_link_if.ctrl                      link,
    input  wire logic [dead_band_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [dead_band_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                           i_wr,
    input  wire logic                           i_rd,
    output logic      [dead_band_pkg::DATA_W-1:0] o_rdata,
    output logic                                o_irq
);
    import dead_band_pkg::*;

    logic [1:0]                     ctrl;
    logic [LEN_W-1:0]               len     [NUM_TIMERS];
    logic [LEN_W-1:0]               count   [NUM_TIMERS];
    logic [NUM_TIMERS-1:0]          running;
    logic [NUM_TIMERS-1:0]          start;
    logic [NUM_TIMERS-1:0]          expire;
    logic                           dma_event;
    logic [NUM_EVENTS-1:0]          status;
    logic [NUM_EVENTS-1:0]          irq_en;
    logic [NUM_EVENTS-1:0]          events;
    logic                           enable;
    logic                           center;

    assign enable = ctrl[CTRL_ENABLE_BIT];
    assign center = ctrl[CTRL_CENTER_BIT];

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Control and lengths; a zero length is taken as one cycle
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ctrl <= CTRL_RESET;
            len[TMR_RISE]  <= LEN_RESET;
            len[TMR_FALL]  <= LEN_RESET;
            len[TMR_PULSE] <= LEN_RESET;
        end else if (i_wr) begin
            if (i_addr == OFS_CTRL) begin
                ctrl <= i_wdata[1:0];
            end
            if (i_addr == OFS_RISE_LEN) begin
                len[TMR_RISE] <= i_wdata[LEN_W-1:0];
            end
            if (i_addr == OFS_FALL_LEN) begin
                len[TMR_FALL] <= i_wdata[LEN_W-1:0];
            end
            if (i_addr == OFS_PULSE) begin
                len[TMR_PULSE] <= i_wdata[LEN_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Timer starts
    // ------------------------------------------------------------------
    // Edge mode: detector starts both delay timers. Center mode: the
    // detector starts the dead-band timer, whose expiry starts the pulse.
    always_comb begin
        start            = '0;
        start[TMR_RISE]  = enable & link.detect_event;
        start[TMR_FALL]  = enable & ~center & link.detect_event;
        start[TMR_PULSE] = enable & center & expire[TMR_RISE];
    end

    // ------------------------------------------------------------------
    // Down-counting timers
    // ------------------------------------------------------------------
    // A restart while running reloads; the later edge wins
    for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
        always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
                running[t] <= 1'b0;
                count[t]   <= '0;
                expire[t]  <= 1'b0;
            end else begin
                expire[t] <= running[t] && (count[t] <= LEN_ONE) && !start[t];
                if (start[t]) begin
                    running[t] <= 1'b1;
                    count[t]   <= len[t];
                end else if (running[t]) begin
                    if (count[t] <= LEN_ONE) begin
                        running[t] <= 1'b0;
                    end
                    count[t] <= count[t] - LEN_ONE;
                end
            end
        end
    end

    // Pulse timer reaching its period limit triggers the DMA event
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            dma_event <= 1'b0;
        end else begin
            dma_event <= expire[TMR_PULSE];
        end
    end

    assign link.center_mode = center;
    assign link.rise_event  = expire[TMR_RISE];
    assign link.fall_event  = expire[TMR_FALL];
    assign link.dma_event   = dma_event;

    // ------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------
    assign events = {dma_event, expire[TMR_FALL], expire[TMR_RISE],
                     link.detect_event};

    // Sticky bits; a new event wins over a clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            status <= '0;
        end else if (i_wr && i_addr == OFS_IRQ_CLR) begin
            status <= (status & ~i_wdata[NUM_EVENTS-1:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            irq_en <= '0;
        end else if (i_wr && i_addr == OFS_IRQ_EN) begin
            irq_en <= i_wdata[NUM_EVENTS-1:0];
        end
    end

    assign o_irq = |(status & irq_en);

    // ------------------------------------------------------------------
    // Read data, one cycle after the strobe; unmapped reads zero
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            unique case (i_addr)
                OFS_CTRL:     o_rdata <= {30'h0, ctrl};
                OFS_RISE_LEN: o_rdata <= {16'h0, len[TMR_RISE]};
                OFS_FALL_LEN: o_rdata <= {16'h0, len[TMR_FALL]};
                OFS_PULSE:    o_rdata <= {16'h0, len[TMR_PULSE]};
                OFS_STATUS:   o_rdata <= {28'h0, status};
                OFS_IRQ_EN:   o_rdata <= {28'h0, irq_en};
                OFS_BUSY:     o_rdata <= {29'h0, running};
                default:      o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end

endmodule

// ### hdl/dead_band_pkg.sv
// Shared constants for the dead-band complementary generator pair.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package dead_band_pkg;

    // ------------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W        = 8;
    localparam int DATA_W        = 32;
    localparam int LEN_W         = 16;
    localparam int NUM_TIMERS    = 3;
    localparam int NUM_EVENTS    = 4;

    // ------------------------------------------------------------------
    // Controller register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_RISE_LEN = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_FALL_LEN = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PULSE    = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_BUSY     = 8'h1c;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CENTER_BIT = 1;
    localparam int TMR_RISE        = 0;
    localparam int TMR_FALL        = 1;
    localparam int TMR_PULSE       = 2;
    localparam int EV_DETECT       = 0;
    localparam int EV_RISE         = 1;
    localparam int EV_FALL         = 2;
    localparam int EV_DMA          = 3;
    localparam logic [1:0]       CTRL_RESET = 2'h0;
    localparam logic [LEN_W-1:0] LEN_RESET  = 16'h0001;
    localparam logic [LEN_W-1:0] LEN_ONE    = 16'h0001;

endpackage

// ### hdl/dead_band_link_if.sv
// Link between the logic cells and the timer/DMA controller.
// Assumes both ends share i_clk; every event is a one-cycle pulse.
`timescale 1ns/1ps

interface dead_band_link_if;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic center_mode;    // Center-aligned operation selected
    logic detect_event;   // Edge detector cell event
    logic rise_event;     // Rising / dead-band timer event
    logic fall_event;     // Falling dead-band timer event
    logic dma_event;      // DMA completion event

    // ------------------------------------------------------------------
    // Modports
    // ------------------------------------------------------------------
    modport cells (
        input  center_mode,
        input  rise_event,
        input  fall_event,
        input  dma_event,
        output detect_event
    );

    modport ctrl (
        output center_mode,
        output rise_event,
        output fall_event,
        output dma_event,
        input  detect_event
    );

endinterface

// ### hdl/dead_band_cells.sv
// Logic-cell end: edge detector and dead-band flip-flops that turn one
// PWM signal into a non-overlapping complementary pair.
// Assumes timer and DMA events arrive from the controller as one-cycle
// pulses on i_clk, and PWM inputs are already synchronous to i_clk.
`timescale 1ns/1ps

module dead_band_cells (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    dead_band_link_if.cells link,
    input  wire logic       i_internal_src_avail,
    input  wire logic       i_single_pwm_source,
    input  wire logic       i_external_cell_input_b,
    output logic            o_rising_delayed_output,
    output logic            o_falling_delayed_output,
    output logic            o_edge_detector_cell
);
    import dead_band_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic pwm;            // Selected PWM input
    logic pwm_prev;       // PWM one cycle ago
    logic cell_out;       // Edge detector cell output
    logic cell_prev;      // Edge detector cell output one cycle ago
    logic detect_event;   // Registered detector event
    logic next_detect;    // Detector event before registering
    logic rise_ff;        // Rising-edge dead-band flop
    logic fall_ff;        // Falling-edge dead-band flop
    logic center_ff;      // Center-aligned output flop
    logic high_raw;       // High-side drive before the interlock
    logic low_raw;        // Low-side drive before the interlock
    logic edge_mode;      // Edge-aligned operation

    assign edge_mode = ~link.center_mode;

    // ------------------------------------------------------------------
    // Input selection
    // ------------------------------------------------------------------
    // Internal routing is preferred; the pin is only a fallback when the
    // PWM source is not among the internal inputs
    assign pwm = i_internal_src_avail ? i_single_pwm_source
                                      : i_external_cell_input_b;

    // ------------------------------------------------------------------
    // Edge detector cell
    // ------------------------------------------------------------------
    // AND of the PWM with itself; center mode inverts the cell output
    assign cell_out = link.center_mode ? ~pwm : pwm;

    // History of the PWM and of the cell output
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pwm_prev  <= 1'b0;
            cell_prev <= 1'b0;
        end else begin
            pwm_prev  <= pwm;
            cell_prev <= cell_out;
        end
    end

    // Edge mode looks for a rise, center mode for a fall of the output.
    // The reset values suppress a false edge in the first cycle.
    always_comb begin
        if (edge_mode) begin
            next_detect = cell_out & ~cell_prev;
        end else begin
            next_detect = ~cell_out & cell_prev;
        end
    end

    // Registered so the controller sees a clean one-cycle pulse
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            detect_event <= 1'b0;
        end else begin
            detect_event <= next_detect;
        end
    end

    assign link.detect_event = detect_event;

    // ------------------------------------------------------------------
    // Rising-edge dead-band flop
    // ------------------------------------------------------------------
    // Reset by the inverted PWM so the output can only rise late and
    // always falls with the PWM. Reset is checked first, so a timer
    // event in the same cycle cannot set the flop.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rise_ff <= 1'b0;
        end else if (~pwm) begin
            rise_ff <= 1'b0;
        end else if (edge_mode && link.rise_event) begin
            rise_ff <= pwm;
        end
    end

    // ------------------------------------------------------------------
    // Falling-edge dead-band flop
    // ------------------------------------------------------------------
    // Mirror image: data is the inverted PWM, reset is the PWM itself,
    // which makes this the delayed complementary phase
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            fall_ff <= 1'b0;
        end else if (pwm) begin
            fall_ff <= 1'b0;
        end else if (edge_mode && link.fall_event) begin
            fall_ff <= ~pwm;
        end
    end

    // ------------------------------------------------------------------
    // Center-aligned output flop
    // ------------------------------------------------------------------
    // The dead-band timer event clocks it and the DMA event clears it,
    // so the pulse width is set by the controller's pulse timer.
    // Limitation: a DMA event that never comes leaves the output high.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            center_ff <= 1'b0;
        end else if (link.dma_event) begin
            center_ff <= 1'b0;
        end else if (link.center_mode && link.rise_event) begin
            center_ff <= pwm;
        end
    end

    // ------------------------------------------------------------------
    // Output pair
    // ------------------------------------------------------------------
    // Edge mode drives the two dead-band flops; center mode pairs the
    // detector output with the center flop
    always_comb begin
        if (edge_mode) begin
            high_raw = rise_ff;
            low_raw  = fall_ff;
        end else begin
            high_raw = center_ff;
            low_raw  = cell_out;
        end
    end

    // Interlock costs one cycle of latency but guarantees that no
    // programming slip can turn both switches of a leg on together
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rising_delayed_output  <= 1'b0;
            o_falling_delayed_output <= 1'b0;
        end else begin
            o_rising_delayed_output  <= high_raw & ~low_raw;
            o_falling_delayed_output <= low_raw & ~high_raw;
        end
    end

    // Detector cell output is also offered to the user side
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_edge_detector_cell <= 1'b0;
        end else begin
            o_edge_detector_cell <= cell_out;
        end
    end

endmodule

// ### tb/dead_band_link_sva.sv
// Concurrent checks on the link between the logic cells and the timer controller.
// Assumes one clock, a synchronous active-high reset and one-cycle event pulses.
`timescale 1ns/1ps

module dead_band_link_sva (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic center_mode,
    input wire logic detect_event,
    input wire logic rise_event,
    input wire logic fall_event,
    input wire logic dma_event,
    input wire logic o_rising_delayed_output,
    input wire logic o_falling_delayed_output,
    input wire logic o_edge_detector_cell
);
    // ------------------------------------------------------------------
    // Clocking and the center-aligned chain
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    // Detection, then dead band, then pulse-width expiry and DMA clear
    sequence center_start_s;
        center_mode && detect_event;
    endsequence
    sequence dead_band_done_s;
        ##[1:40] (center_mode && rise_event);
    endsequence
    property center_chain_p;
        center_start_s |-> dead_band_done_s ##[2:40] dma_event;
    endproperty

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    no_overlap_a: assert property (!(o_rising_delayed_output && o_falling_delayed_output))
        else $error("both drive outputs high together");
    edge_detect_a: assert property (!center_mode && $stable(center_mode)
        && $rose(o_edge_detector_cell) |-> ##[0:1] detect_event) else $error("missed rise event");
    center_detect_a: assert property (center_mode && $stable(center_mode)
        && $fell(o_edge_detector_cell) |-> ##[0:1] detect_event) else $error("missed fall event");
    rise_timer_a: assert property (!center_mode && detect_event |-> ##[1:40] rise_event)
        else $error("rising delay timer never expired");
    fall_timer_a: assert property (!center_mode && detect_event |-> ##[1:40] fall_event)
        else $error("falling delay timer never expired");
    center_chain_a: assert property (center_chain_p)
        else $error("center chain did not complete");
    dma_single_a: assert property (dma_event |=> !dma_event)
        else $error("dma event longer than one cycle");
    rise_hold_a: assert property ((!center_mode && !o_edge_detector_cell)[*2]
        |-> !o_rising_delayed_output) else $error("high side not held low by reset");
    fall_hold_a: assert property ((!center_mode && o_edge_detector_cell)[*2]
        |-> !o_falling_delayed_output) else $error("low side not held low by reset");
    rise_cause_a: assert property ($rose(o_rising_delayed_output)
        |-> $past(rise_event, 2)) else $error("high side rose without timer event");
    fall_cause_a: assert property (!center_mode && $rose(o_falling_delayed_output)
        |-> $past(fall_event, 2)) else $error("low side rose without timer event");
    center_clear_a: assert property (center_mode && dma_event
        |-> ##2 !o_rising_delayed_output) else $error("dma event did not clear high side");
endmodule

// ### tb/tb_dead_band_complementary_gen.sv
// Self-checking bench: controller and logic cells joined by their link,
// driven through the register port. Assumes 100 MHz clock, sync reset.
`timescale 1ns/1ps

`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED t=%0t %s", $time, msg); end end

module tb_dead_band_complementary_gen;
    import dead_band_pkg::*;

    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    localparam int LR = 3;    // Rising / center dead band
    localparam int LF = 5;    // Falling dead band
    localparam int LP = 4;    // Center pulse width
    logic              clk;
    logic              sys_rst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    logic              src_avail;
    logic              pwm_int;
    logic              pwm_ext;
    logic              high_out;
    logic              low_out;
    logic              cell_out;
    logic [31:0]       trace_hi;
    logic [31:0]       trace_lo;
    int                miscompares;
    int                n_checks;
    int                cycles;

    dead_band_link_if dead_band_link_if_inst ();

    dead_band_timer_ctrl dead_band_timer_ctrl_inst (.i_clk(clk), .i_sys_rst(sys_rst),
        .link(dead_band_link_if_inst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .o_irq(irq));

    dead_band_cells dead_band_cells_inst (.i_clk(clk), .i_sys_rst(sys_rst),
        .link(dead_band_link_if_inst), .i_internal_src_avail(src_avail),
        .i_single_pwm_source(pwm_int), .i_external_cell_input_b(pwm_ext),
        .o_rising_delayed_output(high_out), .o_falling_delayed_output(low_out),
        .o_edge_detector_cell(cell_out));

    dead_band_link_sva dead_band_link_sva_inst (.i_clk(clk), .i_sys_rst(sys_rst),
        .center_mode(dead_band_link_if_inst.center_mode),
        .detect_event(dead_band_link_if_inst.detect_event),
        .rise_event(dead_band_link_if_inst.rise_event),
        .fall_event(dead_band_link_if_inst.fall_event),
        .dma_event(dead_band_link_if_inst.dma_event),
        .o_rising_delayed_output(high_out), .o_falling_delayed_output(low_out),
        .o_edge_detector_cell(cell_out));

    // Free-running clock and a cycle ceiling so a hang still ends the run
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            $display("CHECK FAILED t=%0t run timed out", $time);
            complete_run();
        end
    end

    // ------------------------------------------------------------------
    // Bus and waveform tasks
    // ------------------------------------------------------------------
    // Every task that drives the bus or the PWM starts on an edge, so strobes never change twice in one step
    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        `CHK(rdata, exp, "register read")
    endtask

    // One PWM pulse of h cycles on the selected source; trace bit k is after edge k
    task automatic run_pulse(input int h);
        @(posedge clk);
        if (src_avail) pwm_int <= 1'b1; else pwm_ext <= 1'b1;
        for (int k = 0; k < 32; k++) begin
            #1;
            trace_hi[k] = high_out;
            trace_lo[k] = low_out;
            @(posedge clk);
            if (k + 1 == h) begin
                if (src_avail) pwm_int <= 1'b0; else pwm_ext <= 1'b0;
            end
        end
    endtask

    // High side expected in [ha,hb]; low side in [la,lb] or [ma,mb]
    task automatic check_trace(input int ha, hb, la, lb, ma, mb);
        logic [31:0] eh;
        logic [31:0] el;
        for (int k = 0; k < 32; k++) begin
            eh[k] = (k >= ha && k <= hb);
            el[k] = (k >= la && k <= lb) || (k >= ma && k <= mb);
        end
        `CHK(trace_hi, eh, "high-side waveform")
        `CHK(trace_lo, el, "low-side waveform")
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset();
        rd_chk(OFS_CTRL, 32'h0000_0000);
        rd_chk(OFS_RISE_LEN, 32'h0000_0001);
        rd_chk(OFS_STATUS, 32'h0000_0000);
        rd_chk(8'h40, 32'h0000_0000);    // Unmapped reads back zero
        rd_chk(OFS_BUSY, 32'h0000_0000);    // No timer runs after reset
        `CHK({irq, high_out, low_out, cell_out}, 4'h0, "idle outputs after reset")
        $display("test reset done");
    endtask

    // Long pulse: high side follows after the rising dead band, low side never sets
    task automatic test_edge_long();
        reg_wr(OFS_RISE_LEN, 32'(LR));
        reg_wr(OFS_FALL_LEN, 32'(LF));
        reg_wr(OFS_CTRL, 32'h0000_0001);
        run_pulse(10);
        check_trace(LR + 4, 11, 1, 0, 1, 0);
        rd_chk(OFS_FALL_LEN, 32'(LF));
        rd_chk(OFS_STATUS, 32'h0000_0007);
        reg_wr(OFS_IRQ_EN, 32'h0000_0002);
        #1 `CHK(irq, 1'b1, "enabled rise event raises irq")
        reg_wr(OFS_IRQ_CLR, 32'h0000_0002);
        #1 `CHK(irq, 1'b0, "cleared event drops irq")
        rd_chk(OFS_STATUS, 32'h0000_0005);
        $display("test edge_long done");
    endtask

    // Short pulse on the external pin while the internal source is held high
    task automatic test_edge_short_ext();
        reg_wr(OFS_IRQ_CLR, 32'h0000_000f);
        @(posedge clk);
        src_avail <= 1'b0;
        pwm_int   <= 1'b1;
        run_pulse(2);
        check_trace(1, 0, LF + 4, 31, 1, 0);
        @(posedge clk);
        pwm_int   <= 1'b0;
        src_avail <= 1'b1;
        $display("test edge_short_ext done");
    endtask

    // Center mode: dead band, pulse width, then DMA clears the high side
    task automatic test_center();
        reg_wr(OFS_IRQ_CLR, 32'h0000_000f);
        reg_wr(OFS_RISE_LEN, 32'(LR));
        reg_wr(OFS_PULSE, 32'(LP));
        reg_wr(OFS_CTRL, 32'h0000_0003);
        repeat (4) @(posedge clk);
        `CHK(cell_out, 1'b1, "detector output inverted in center mode")
        run_pulse(14);
        check_trace(LR + 4, LR + LP + 5, 0, 0, 15, 31);
        rd_chk(OFS_PULSE, 32'(LP));
        rd_chk(OFS_STATUS, 32'h0000_000b);
        reg_wr(OFS_IRQ_EN, 32'h0000_0008);
        #1 `CHK(irq, 1'b1, "dma event raises irq")
        reg_wr(OFS_IRQ_EN, 32'h0000_0000);
        #1 `CHK(irq, 1'b0, "masked status keeps irq low")
        $display("test center done");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        {addr, wdata, wr, rd, pwm_int, pwm_ext} = '0;
        src_avail = 1'b1;
        miscompares = 0;
        n_checks = 0;
        cycles = 0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        test_reset();
        test_edge_long();
        test_edge_short_ext();
        test_center();
        complete_run();
    end
endmodule
